// ---- core/ibc_controller.sv ----
// Expansion bus cycle controller: clocking, address latch, command and wait logic
`timescale 1ns/1ps
module ibc_controller
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic async_mode,
    input wire logic doubled_clock_input,
    input wire logic bus_oscillator_input,
    input wire logic [23:0] cpu_addr,
    input wire logic cpu_m_io,
    input wire logic [1:0] cpu_status_n,
    input wire logic cpu_bhe_n,
    input wire logic [15:0] cpu_data_in,
    output logic [15:0] cpu_data_out,
    output logic cpu_data_oe_n,
    output logic cpu_ready_n,
    output logic cpu_clock,
    output logic bus_clock,
    output logic system_addr_latch_en,
    output logic fast_addr_latch_en,
    output logic bale,
    output logic sa0,
    output ibc_pkg::ibc_cmd_t cmd,
    input wire logic memcs16_n,
    input wire logic iocs16_n,
    input wire logic zero_ws_n,
    input wire logic iochrdy,
    input wire logic [15:0] sd_in,
    output logic high_byte_buf_en_n,
    output logic low_byte_buf_en_n
);
    import ibc_pkg::*;

    localparam int PIN_W = 67;

    logic [PIN_W-1:0] pins_raw;
    logic [PIN_W-1:0] pins_s;
    logic dci_s, boi_s, mode_async, m_io_s, bhe_n_s, memcs16_s, iocs16_s, zws_s, rdy_s;
    logic [1:0] status_n_s;
    logic [23:0] addr_s;
    logic [15:0] sd_s, cpu_d_s;

    // Every pin but clk_sys and resetn, processor strobes included, is resynchronised before use
    assign pins_raw = {async_mode, doubled_clock_input, bus_oscillator_input, cpu_m_io,
                       cpu_status_n, cpu_bhe_n, cpu_addr, memcs16_n, iocs16_n, zero_ws_n,
                       iochrdy, sd_in, cpu_data_in};

    ibc_sync #(.WIDTH(PIN_W)) u_sync
    (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .async_in(pins_raw),
        .sync_out(pins_s)
    );

    assign {mode_async, dci_s, boi_s, m_io_s, status_n_s, bhe_n_s, addr_s, memcs16_s,
            iocs16_s, zws_s, rdy_s, sd_s, cpu_d_s} = pins_s;

    logic dci_d, boi_d, div_cnt;
    logic [7:0] bus_wait_control;
    ibc_bus_state_t state;
    ibc_access_t acc;
    logic pending, status_seen, width16, split, second_pass, strobe_on, zws_hit;
    logic ready_hold, drive_active;
    logic [2:0] ws_left;
    logic [7:0] rd_lo, rd_hi;

    wire cpu_tick = dci_s & ~dci_d;
    wire boi_rise = boi_s & ~boi_d;
    wire half_tick = mode_async ? boi_rise : (cpu_tick & div_cnt);
    wire state_start = half_tick & ~bus_clock;
    wire state_mid = half_tick & bus_clock;

    // Processor status decode during the second status phase
    wire status_act = ~(&status_n_s);
    wire is_read = ~status_n_s[1] & status_n_s[0];
    wire is_write = status_n_s[1] & ~status_n_s[0];
    wire is_word = ~bhe_n_s & ~addr_s[0];
    wire is_internal = ~m_io_s & (addr_s[15:0] == BUS_WAIT_CONTROL_ADDR);
    wire new_cycle = cpu_tick & status_act & ~status_seen & (is_read | is_write)
                     & state == BUS_IDLE & ~pending;

    wire [2:0] ws8 = WS8_BASE + {1'b0, bus_wait_control[WS8_LSB+1:WS8_LSB]};
    wire [2:0] ws16 = {1'b0, bus_wait_control[WS16_LSB+1:WS16_LSB]};
    wire [2:0] ws_prog = width16 ? ws16 : ws8;

    // 0WS wins over every other term, IOCHRDY only counts after programmed waits
    wire end_cmd = zws_hit | (ws_prog == 3'h0 & rdy_s);
    wire end_wait = zws_hit | (ws_left <= 3'h1 & rdy_s);
    wire early_strobe = acc.is_mem & acc.is_word & ~memcs16_s;

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            dci_d <= 1'b0;
            boi_d <= 1'b0;
            div_cnt <= 1'b0;
            bus_clock <= 1'b0;
        end
        else
        begin
            dci_d <= dci_s;
            boi_d <= boi_s;
            if (cpu_tick)
            begin
                div_cnt <= ~div_cnt;
            end
            if (half_tick)
            begin
                bus_clock <= ~bus_clock;
            end
        end
    end

    assign cpu_clock = dci_s;

    // Processor side: latch enables and access capture
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            status_seen <= 1'b0;
            system_addr_latch_en <= 1'b0;
            acc <= '0;
            pending <= 1'b0;
        end
        else
        begin
            if (cpu_tick)
            begin
                status_seen <= status_act;
                system_addr_latch_en <= new_cycle;
            end
            if (new_cycle)
            begin
                acc <= '{addr: addr_s, is_mem: m_io_s, is_read: is_read,
                         is_word: is_word, is_internal: is_internal};
                pending <= 1'b1;
            end
            else if (state == BUS_DONE & cpu_tick)
            begin
                pending <= 1'b0;
            end
        end
    end

    // Register write from a processor IO cycle at the documented address
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            bus_wait_control <= BUS_WAIT_CONTROL_RESET;
        end
        else if (state == BUS_IDLE & pending & acc.is_internal & ~acc.is_read)
        begin
            bus_wait_control <= cpu_d_s[7:0];
        end
    end

    // Bus side state machine, stepped in half bus states
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            state <= BUS_IDLE;
            fast_addr_latch_en <= 1'b0;
            bale <= 1'b0;
            width16 <= 1'b0;
            split <= 1'b0;
            second_pass <= 1'b0;
            strobe_on <= 1'b0;
            zws_hit <= 1'b0;
            ws_left <= 3'h0;
            rd_lo <= 8'h00;
            rd_hi <= 8'h00;
        end
        else
        begin
            // Register cycles never reach the command state that would drop it
            if (new_cycle & ~is_internal)
            begin
                fast_addr_latch_en <= 1'b1;
            end
            unique case (state)
                BUS_IDLE:
                begin
                    if (pending & acc.is_internal)
                    begin
                        state <= BUS_DONE;
                        rd_lo <= bus_wait_control;
                        rd_hi <= 8'h00;
                    end
                    else if (pending & state_start)
                    begin
                        state <= BUS_STATUS;
                        zws_hit <= 1'b0;
                    end
                end
                BUS_STATUS:
                begin
                    if (state_mid)
                    begin
                        bale <= ~second_pass;
                    end
                    if (state_start)
                    begin
                        bale <= 1'b0;
                        state <= BUS_COMMAND;
                        width16 <= acc.is_word & (acc.is_mem ? ~memcs16_s : 1'b1);
                        strobe_on <= early_strobe & ~second_pass;
                    end
                end
                BUS_COMMAND:
                begin
                    if (state_mid)
                    begin
                        if (!acc.is_mem & acc.is_word & !second_pass)
                        begin
                            width16 <= ~iocs16_s;
                        end
                        strobe_on <= 1'b1;
                        fast_addr_latch_en <= 1'b0;
                        zws_hit <= ~zws_s;
                    end
                    if (state_start)
                    begin
                        ws_left <= ws_prog;
                        if (end_cmd)
                        begin
                            state <= BUS_DONE;
                        end
                        else
                        begin
                            state <= BUS_WAIT;
                        end
                    end
                end
                BUS_WAIT:
                begin
                    if (state_mid)
                    begin
                        zws_hit <= zws_hit | ~zws_s;
                    end
                    if (state_start)
                    begin
                        if (end_wait)
                        begin
                            state <= BUS_DONE;
                        end
                        else if (ws_left != 3'h0)
                        begin
                            ws_left <= ws_left - 3'h1;
                        end
                    end
                end
                BUS_DONE:
                begin
                    if (cpu_tick)
                    begin
                        state <= BUS_IDLE;
                        second_pass <= 1'b0;
                        split <= 1'b0;
                    end
                end
                default:
                begin
                    state <= BUS_IDLE;
                end
            endcase
            // Cycle end: strobe off, capture read data, maybe run the high byte
            if ((state == BUS_COMMAND & state_start & end_cmd)
                | (state == BUS_WAIT & state_start & end_wait))
            begin
                strobe_on <= 1'b0;
                zws_hit <= 1'b0;
                if (acc.is_word & ~width16 & ~second_pass)
                begin
                    state <= BUS_IDLE;
                    second_pass <= 1'b1;
                    split <= 1'b1;
                    rd_lo <= sd_s[7:0];
                end
                else if (split)
                begin
                    rd_hi <= sd_s[7:0];
                end
                else if (acc.is_word)
                begin
                    rd_lo <= sd_s[7:0];
                    rd_hi <= sd_s[15:8];
                end
                else
                begin
                    rd_lo <= sd_s[7:0];
                    rd_hi <= sd_s[7:0];
                end
            end
        end
    end

    // Ready held until the next processor clock tick, at most one phase; the bus cycle is already over by then
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            ready_hold <= 1'b0;
            drive_active <= 1'b0;
        end
        else
        begin
            ready_hold <= (state == BUS_DONE);
            if (state == BUS_DONE & acc.is_read & (mode_async | acc.is_internal))
            begin
                drive_active <= 1'b1;
            end
            else if (cpu_tick & ~ready_hold)
            begin
                drive_active <= 1'b0;
            end
        end
    end

    assign cpu_ready_n = ~ready_hold;
    assign cpu_data_out = {rd_hi, rd_lo};
    assign cpu_data_oe_n = ~drive_active;
    assign sa0 = acc.addr[0] | second_pass;

    wire bus_busy = state != BUS_IDLE & ~acc.is_internal;
    // Buffers off while the device drives latched data, avoiding contention
    wire high_lane = acc.is_word | acc.addr[0];
    assign high_byte_buf_en_n = ~(bus_busy & ~drive_active & high_lane);
    assign low_byte_buf_en_n = ~(bus_busy & ~drive_active);

    // Only one strobe can be low: type bits are exclusive
    assign cmd.ior_n = ~(strobe_on & ~acc.is_mem & acc.is_read);
    assign cmd.iow_n = ~(strobe_on & ~acc.is_mem & ~acc.is_read);
    assign cmd.memr_n = ~(strobe_on & acc.is_mem & acc.is_read);
    assign cmd.memw_n = ~(strobe_on & acc.is_mem & ~acc.is_read);
endmodule : ibc_controller

// ---- core/ibc_pkg.sv ----
// Shared constants and types for the expansion bus cycle controller
package ibc_pkg;
    localparam logic [15:0] BUS_WAIT_CONTROL_ADDR = 16'hFC80;
    localparam logic [7:0] BUS_WAIT_CONTROL_RESET = 8'h00;
    localparam int WS16_LSB = 3;
    localparam int WS8_LSB = 5;
    localparam logic [2:0] WS8_BASE = 3'h2;
    localparam int DOUBLE_DIV_HALF = 2;
    localparam int SYNC_STAGES = 2;

    typedef enum logic [2:0]
    {
        BUS_IDLE = 3'b000,
        BUS_STATUS = 3'b001,
        BUS_COMMAND = 3'b010,
        BUS_WAIT = 3'b011,
        BUS_DONE = 3'b100
    } ibc_bus_state_t;

    typedef struct packed
    {
        logic [23:0] addr;
        logic is_mem;
        logic is_read;
        logic is_word;
        logic is_internal;
    } ibc_access_t;

    typedef struct packed
    {
        logic ior_n;
        logic iow_n;
        logic memr_n;
        logic memw_n;
    } ibc_cmd_t;
endpackage : ibc_pkg

// ---- core/ibc_sync.sv ----
// Two-stage synchroniser for a group of pin inputs
`timescale 1ns/1ps
module ibc_sync
#(
    parameter int WIDTH = 1
)
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    import ibc_pkg::*;

    logic [WIDTH-1:0] stage1;

    // First stage feeds only the second
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            stage1 <= '0;
            sync_out <= '0;
        end
        else
        begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end
endmodule : ibc_sync

// ---- tb/ibc_controller_checker.sv ----
// Assertion checker for the controller's processor and bus pins
`timescale 1ns/1ps
module ibc_controller_checker
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic cpu_ready_n,
    input wire logic cpu_data_oe_n,
    input wire logic [15:0] cpu_data_out,
    input wire logic bale,
    input wire logic fast_addr_latch_en,
    input wire ibc_pkg::ibc_cmd_t cmd,
    input wire logic iochrdy,
    input wire logic zero_ws_n,
    input wire logic high_byte_buf_en_n,
    input wire logic low_byte_buf_en_n
);
    import ibc_pkg::*;
    logic act;
    assign act = cmd != 4'hF;
    default clocking dc @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);
    one_strobe_a: assert property ($onehot0(~cmd))
        else $error("two strobes low");
    bale_fast_a: assert property (bale |-> fast_addr_latch_en)
        else $error("bale without fast latch");
    bale_idle_a: assert property (act |-> !bale)
        else $error("bale during command");
    ready_idle_a: assert property (!cpu_ready_n |-> !act)
        else $error("ready while strobe low");
    ready_pulse_a: assert property ($fell(cpu_ready_n) |-> ##[1:12] cpu_ready_n)
        else $error("ready stuck low");
    buf_off_a: assert property (!cpu_data_oe_n |->
        high_byte_buf_en_n && low_byte_buf_en_n)
        else $error("buffers on while driving");
    data_hold_a: assert property (!cpu_data_oe_n && $past(!cpu_data_oe_n) |->
        $stable(cpu_data_out))
        else $error("latched data moved");
    end_cause_a: assert property ($fell(act) |-> $past(iochrdy) || !$past(zero_ws_n))
        else $error("cycle ended while held");
    cover property ($fell(cmd.ior_n));
    cover property ($fell(cpu_data_oe_n));
    cover property ($fell(act) && !$past(zero_ws_n));
endmodule : ibc_controller_checker

bind ibc_controller ibc_controller_checker u_chk (.clk_sys, .resetn, .cpu_ready_n,
    .cpu_data_oe_n, .cpu_data_out, .bale, .fast_addr_latch_en, .cmd, .iochrdy,
    .zero_ws_n, .high_byte_buf_en_n, .low_byte_buf_en_n);

// ---- tb/ibc_board.sv ----
// Expansion board model: selects, zero wait, ready stretch, read data
`timescale 1ns/1ps
module ibc_board
(
    input wire logic clk_sys,
    input wire ibc_pkg::ibc_cmd_t cmd,
    input wire logic bale,
    input wire logic is16,
    input wire logic zws,
    input wire logic [7:0] hold,
    output logic memcs16_n,
    output logic iocs16_n,
    output logic zero_ws_n,
    output logic iochrdy,
    output logic [15:0] sd_in,
    output logic [3:0] seen,
    output int cnt
);
    import ibc_pkg::*;
    logic act, rd, was = 1'h0, stall = 1'h0, fast = 1'h0;
    logic [15:0] sd_q = 16'h0000;
    int run = 0;
    assign act = cmd != 4'hF;
    assign rd = !(cmd.ior_n && cmd.memr_n);
    assign memcs16_n = !is16;
    assign iocs16_n = !is16;
    assign zero_ws_n = !fast;
    assign iochrdy = !stall;
    // Released lanes toggle so a stale latch cannot pass
    assign sd_in = rd ? {8'hC3, 8'h10 + cnt[7:0]} : ~sd_q;
    initial cnt = 0;
    initial seen = 4'hF;
    always @(posedge clk_sys)
    begin
        sd_q <= sd_in;
        was <= act;
        run <= act ? run + 1 : 0;
        if (bale)
        begin
            stall <= hold != 8'h00;
            fast <= zws;
        end
        if (act && !was)
        begin
            cnt <= cnt + 1;
            seen <= cmd;
        end
        if ((act && run >= int'(hold)) || (!act && was))
            stall <= 1'h0;
        if (!act && was)
            fast <= 1'h0;
    end
endmodule : ibc_board

// ---- tb/isa_bus_cycle_controller_test.sv ----
// Self-checking bench for the expansion bus cycle controller
`timescale 1ns/1ps
module isa_bus_cycle_controller_test;
    import ibc_pkg::*;
    logic clk_sys = 1'h0, resetn = 1'h0, async_mode = 1'h0, is16 = 1'h0, zws = 1'h0;
    logic doubled_clock_input = 1'h0, bus_oscillator_input = 1'h0, cpu_m_io = 1'h0;
    logic cpu_bhe_n = 1'h1, cpu_ready_n, cpu_data_oe_n, bale, memcs16_n, iocs16_n;
    logic zero_ws_n, iochrdy, high_byte_buf_en_n, low_byte_buf_en_n, sa0, sa_hi;
    logic [23:0] cpu_addr = 24'h000000;
    logic [1:0] cpu_status_n = 2'h3;
    logic [15:0] cpu_data_in = 16'h0000, cpu_data_out, sd_in, rdat;
    logic [7:0] hold = 8'h00;
    logic [3:0] seen;
    ibc_cmd_t cmd;
    int cnt, nlow, error_cnt = 0, checks_done = 0, cyc_n = 0;
    always #5 clk_sys = ~clk_sys;
    always #20 doubled_clock_input = ~doubled_clock_input;
    // Odd half period keeps the oscillator unrelated to clk_sys
    always #31 bus_oscillator_input = ~bus_oscillator_input;
    ibc_controller dut (.clk_sys, .resetn, .async_mode, .doubled_clock_input,
        .bus_oscillator_input, .cpu_addr, .cpu_m_io, .cpu_status_n, .cpu_bhe_n,
        .cpu_data_in, .cpu_data_out, .cpu_data_oe_n, .cpu_ready_n, .cpu_clock(),
        .bus_clock(), .system_addr_latch_en(), .fast_addr_latch_en(), .bale, .sa0,
        .cmd, .memcs16_n, .iocs16_n, .zero_ws_n, .iochrdy, .sd_in,
        .high_byte_buf_en_n, .low_byte_buf_en_n);
    ibc_board board (.clk_sys, .cmd, .bale, .is16, .zws, .hold, .memcs16_n,
        .iocs16_n, .zero_ws_n, .iochrdy, .sd_in, .seen, .cnt);
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checks_done++;
        if (g !== e)
        begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic summarize();
        $display("mismatches %0d comparisons %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : summarize
    // Processor cycle: held from a tick until ready is seen, released a tick later
    task automatic cyc(input logic [23:0] a, input logic mio, input logic wr,
        input logic bh, input logic [7:0] wd);
        int t;
        @(posedge doubled_clock_input);
        @(negedge clk_sys);
        cpu_addr = a;
        cpu_m_io = mio;
        cpu_bhe_n = bh;
        cpu_data_in = {8'h00, wd};
        cpu_status_n = wr ? 2'h2 : 2'h1;
        t = 0;
        nlow = 0;
        sa_hi = 1'h0;
        while (cpu_ready_n !== 1'h0 && t < 3000)
        begin
            @(negedge clk_sys);
            t++;
            if (cmd !== 4'hF)
                nlow++;
            if (cmd !== 4'hF && sa0 === 1'h1)
                sa_hi = 1'h1;
        end
        rdat = cpu_data_out;
        chk("ready", 16'h0000, {15'h0000, cpu_ready_n});
        @(posedge doubled_clock_input);
        @(negedge clk_sys);
        cpu_status_n = 2'h3;
    endtask : cyc
    task automatic wreg(input logic [7:0] v);
        cyc(24'h00FC80, 1'h0, 1'h1, 1'h1, v);
    endtask : wreg
    task automatic t_reg();
        wreg(8'h78);
        cyc(24'h00FC80, 1'h0, 1'h0, 1'h1, 8'h00);
        chk("control reg", 16'h0078, rdat);
    endtask : t_reg
    task automatic t_types();
        logic [3:0] exp [4] = '{4'h7, 4'hB, 4'hD, 4'hE};
        int c0;
        wreg(8'h00);
        for (int i = 0; i < 4; i++)
        begin
            c0 = cnt;
            cyc(24'h0D0000, i[1], i[0], 1'h1, 8'h00);
            chk("strobe kind", {8'h00, exp[i], 4'h1}, {8'h00, seen, 4'(cnt - c0)});
        end
    endtask : t_types
    task automatic t_ws();
        int a, b;
        is16 = 1'h1;
        cyc(24'h0D0000, 1'h1, 1'h0, 1'h0, 8'h00);
        a = nlow;
        is16 = 1'h0;
        cyc(24'h0D0000, 1'h1, 1'h0, 1'h1, 8'h00);
        b = nlow;
        chk("byte delay", 16'h0018, 16'(b - a));
        wreg(8'h78);
        is16 = 1'h1;
        cyc(24'h0D0000, 1'h1, 1'h0, 1'h0, 8'h00);
        chk("word waits", 16'h0030, 16'(nlow - a));
        is16 = 1'h0;
        cyc(24'h0D0000, 1'h1, 1'h0, 1'h1, 8'h00);
        chk("byte waits", 16'h0030, 16'(nlow - b));
    endtask : t_ws
    task automatic t_hold();
        zws = 1'h1;
        hold = 8'hC8;
        cyc(24'h0D0000, 1'h1, 1'h0, 1'h1, 8'h00);
        chk("zero wait", 16'h0008, 16'(nlow));
        zws = 1'h0;
        hold = 8'h78;
        is16 = 1'h1;
        cyc(24'h0D0000, 1'h1, 1'h0, 1'h0, 8'h00);
        chk("stretch", 16'h0001, {15'h0000, nlow >= 120 && nlow <= 156});
        hold = 8'h00;
    endtask : t_hold
    task automatic t_async();
        int c0;
        @(negedge clk_sys);
        async_mode = 1'h1;
        repeat (8) @(negedge clk_sys);
        c0 = cnt;
        cyc(24'h0D0000, 1'h1, 1'h0, 1'h0, 8'h00);
        chk("async word", {8'hC3, 8'(8'h11 + c0)}, rdat);
        chk("word sa0", 16'h0000, {15'h0000, sa_hi});
        is16 = 1'h0;
        c0 = cnt;
        cyc(24'h0D0000, 1'h1, 1'h0, 1'h0, 8'h00);
        chk("async split", {8'(8'h12 + c0), 8'(8'h11 + c0)}, rdat);
        chk("split sa0", 16'h0001, {15'h0000, sa_hi});
    endtask : t_async
    always @(posedge clk_sys)
    begin
        cyc_n++;
        if (cyc_n == 60000)
        begin
            error_cnt++;
            summarize();
        end
    end
    initial
    begin
        repeat (6) @(negedge clk_sys);
        chk("reset pins", 16'h00FF, {8'h00, cmd, cpu_ready_n, cpu_data_oe_n,
            high_byte_buf_en_n, low_byte_buf_en_n});
        resetn = 1'h1;
        repeat (3) @(negedge clk_sys);
        t_reg();
        t_types();
        t_ws();
        t_hold();
        t_async();
        summarize();
    end
endmodule : isa_bus_cycle_controller_test
